// [verilog/cdtl_pkg.sv]
package cdtl_pkg;

   // ------------------------------------------------------------
   // Line rate and clocking
   // ------------------------------------------------------------
   localparam int BIT_RATE_BPS = 64000;
   localparam int MCLK_HZ = 250000000;
   // Rounded down: a bit slot is never longer than the nominal period
   localparam int BIT_TICK_CYCLES = MCLK_HZ / BIT_RATE_BPS;
   localparam int TICK_CNT_W = 12;

   // ------------------------------------------------------------
   // Octet timing
   // ------------------------------------------------------------
   localparam int OCTET_BITS = 8;
   // Bit 8 of the octet, the least significant one, is slot index 7
   localparam logic [2:0] OCTET_MARK_IDX = 3'h7;
   localparam logic [2:0] OCTET_IDX_RESET = 3'h0;

   // ------------------------------------------------------------
   // Switch sampling
   // ------------------------------------------------------------
   localparam int SW_OCTET = 0;
   localparam int SW_MODE_A = 1;
   localparam int SW_MODE_B = 2;
   localparam int SW_COUNT = 3;
   localparam logic [1:0] CFG_CNT_RESET = 2'h0;
   localparam logic [1:0] CFG_LOAD_CNT = 2'h2;
   localparam logic [1:0] CFG_DONE_CNT = 2'h3;
   localparam logic OCTET_EN_RESET = 1'h0;
   localparam logic RX_INVERT_DEF = 1'h0;

   // Code is {timingModeSwitchB, timingModeSwitchA}; Gray order along the list
   typedef enum logic [1:0] {
      MODE_LOOP = 2'h0,
      MODE_INTERNAL = 2'h1,
      MODE_DUAL = 2'h3,
      MODE_MINLOOP = 2'h2
   } cdtl_mode_t;

   localparam cdtl_mode_t MODE_RESET = MODE_LOOP;

endpackage

// [verilog/cdtl_evt_sync.sv]
module cdtl_evt_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic ce,
   input wire logic srcTog,
   input wire logic [W-1:0] srcData,
   output logic evtPulse,
   output logic [W-1:0] evtData
);
   import cdtl_pkg::*;

   logic meta_r;
   logic sync_r;
   logic last_r;
   logic pulse_r;
   logic pulse_nxt;
   logic [W-1:0] data_r;
   logic [W-1:0] data_nxt;

   if (W < 1) begin : g_chk
      $error("cdtl_evt_sync: W must be at least 1");
   end

   // Source data is held from its toggle until the next one, so it is
   // settled by the time the synchronised toggle is seen here
   always_comb begin
      pulse_nxt = sync_r ^ last_r;
      data_nxt = pulse_nxt ? srcData : data_r;
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         meta_r <= 1'h0;
         sync_r <= 1'h0;
         last_r <= 1'h0;
         pulse_r <= 1'h0;
         data_r <= '0;
      end else if (ce) begin
         meta_r <= srcTog;
         sync_r <= meta_r;
         last_r <= sync_r;
         pulse_r <= pulse_nxt;
         data_r <= data_nxt;
      end
   end

   assign evtPulse = pulse_r;
   assign evtData = data_r;

endmodule

// [verilog/cdtl_bit_clock.sv]
module cdtl_bit_clock #(
   parameter int CYCLES = cdtl_pkg::BIT_TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic en,
   output logic tickTog
);
   import cdtl_pkg::*;

   logic [TICK_CNT_W-1:0] cnt_r;
   logic [TICK_CNT_W-1:0] cnt_nxt;
   logic tog_r;
   logic tog_nxt;

   if (CYCLES < 2 || CYCLES > (1 << TICK_CNT_W)) begin : g_chk
      $error("cdtl_bit_clock: CYCLES out of range");
   end

   always_comb begin
      cnt_nxt = '0;
      tog_nxt = tog_r;
      if (en) begin
         if (cnt_r == TICK_CNT_W'(CYCLES - 1)) begin
            tog_nxt = ~tog_r;
         end else begin
            cnt_nxt = cnt_r + TICK_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
         tog_r <= 1'h0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         tog_r <= tog_nxt;
      end
   end

   assign tickTog = tog_r;

   a_tick_rate: assert property (@(posedge mclk) disable iff (!nrst)
      (ce && en && cnt_r == TICK_CNT_W'(CYCLES - 1)) |=> (tog_r != $past(tog_r))) // RL15
      else $error("bit clock missed its slot");

endmodule

// [verilog/cdtl_line_timing.sv]
// How it works
// [RL1] Octet switch off: no octet marker; on: 8 kHz marker on the line, except in minimum loopback, which sends none.
// [RL2] Mode switches B,A: 00 loop, 01 internal, 10 minimum loopback, 11 dual.
// [RL3] The octet marker sits on bit 8, the last bit of each octet.
// [RL4] Internal timing: line transmit slots come from the local bit clock only.
// [RL5] Loop timing: line transmit slots follow the recovered receive clock.
// [RL6] Minimum loopback: line input latched, polarity restored, sent straight back.
// [RL7] Minimum loopback: internal data still reaches the line stage, then dropped.
// [RL8] Minimum loopback: line receive keeps feeding the internal transmitter.
// [RL9] Minimum loopback: timing returned as received; partner supplies the clock.
// [RL10] Dual loopback: internal receive data echoed to the internal transmitter.
// [RL11] Dual loopback: line receive data returned to the line transmitter.
// [RL12] Dual loopback: both far ends must each supply their own timing.
// [RL13] Relay to relay: octet off, internal timing recommended.
// [RL14] Multiplexer link, factory default: octet on, loop timing recommended.
// [RL15] Line runs at fixed 64 kbit/s; no rate setting exists.
// [RL16] Switches are static, sampled only just after reset release.
module cdtl_line_timing #(
   parameter logic RX_INVERT = cdtl_pkg::RX_INVERT_DEF
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic lineClk,
   input wire logic octetTimingSwitch,
   input wire logic timingModeSwitchA,
   input wire logic timingModeSwitchB,
   input wire logic dmRxBit,
   input wire logic dmRxValid,
   input wire logic lineRxBit,
   output logic dmTxBit,
   output logic dmTxValid,
   output logic lineTxBit,
   output logic lineTxValid,
   output logic lineTxOctet,
   output cdtl_pkg::cdtl_mode_t activeMode,
   output logic octetActive,
   output logic cfgReady
);
   import cdtl_pkg::*;

   // ------------------------------------------------------------
   // Internal clock domain: switch capture
   // ------------------------------------------------------------
   logic [SW_COUNT-1:0] swMeta_r;
   logic [SW_COUNT-1:0] swSync_r;
   logic [1:0] cfgCnt_r;
   logic [1:0] cfgCnt_nxt;
   cdtl_mode_t mode_r;
   cdtl_mode_t mode_nxt;
   logic octetEn_r;
   logic octetEn_nxt;
   logic cfgDone_r;
   logic cfgDone_nxt;

   // The synchroniser needs two edges to fill, so the load waits for it
   always_comb begin
      cfgCnt_nxt = cfgCnt_r;
      mode_nxt = mode_r;
      octetEn_nxt = octetEn_r;
      cfgDone_nxt = cfgDone_r;
      if (cfgCnt_r != CFG_DONE_CNT) begin
         cfgCnt_nxt = cfgCnt_r + 2'h1;
      end
      if (cfgCnt_r == CFG_LOAD_CNT) begin
         mode_nxt = cdtl_mode_t'({swSync_r[SW_MODE_B], swSync_r[SW_MODE_A]}); // RL2 RL16
         octetEn_nxt = swSync_r[SW_OCTET]; // RL16
      end
      if (cfgCnt_r == CFG_DONE_CNT) begin
         cfgDone_nxt = 1'h1;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         swMeta_r <= '0;
         swSync_r <= '0;
         cfgCnt_r <= CFG_CNT_RESET;
         mode_r <= MODE_RESET;
         octetEn_r <= OCTET_EN_RESET;
         cfgDone_r <= 1'h0;
      end else if (ce) begin
         swMeta_r <= {timingModeSwitchB, timingModeSwitchA, octetTimingSwitch};
         swSync_r <= swMeta_r;
         cfgCnt_r <= cfgCnt_nxt;
         mode_r <= mode_nxt;
         octetEn_r <= octetEn_nxt;
         cfgDone_r <= cfgDone_nxt;
      end
   end

   // ------------------------------------------------------------
   // Internal clock domain: data paths
   // ------------------------------------------------------------
   logic tickTog;
   logic ldPulse;
   logic ldBit;
   logic dlBit_r;
   logic dlBit_nxt;
   logic dlTog_r;
   logic dlTog_nxt;
   logic dmTxBit_r;
   logic dmTxBit_nxt;
   logic dmTxValid_r;
   logic dmTxValid_nxt;
   logic ldBitL_r;
   logic ldTogL_r;

   cdtl_bit_clock u_bitClock (
      .mclk(mclk),
      .nrst(nrst),
      .ce(ce),
      .en(cfgDone_r && mode_r == MODE_INTERNAL), // RL4
      .tickTog(tickTog)
   );

   cdtl_evt_sync #(.W(1)) u_lineToDm (
      .clk(mclk),
      .rstN(nrst),
      .ce(ce),
      .srcTog(ldTogL_r),
      .srcData(ldBitL_r),
      .evtPulse(ldPulse),
      .evtData(ldBit)
   );

   always_comb begin
      dlBit_nxt = dlBit_r;
      dlTog_nxt = dlTog_r;
      dmTxBit_nxt = dmTxBit_r;
      dmTxValid_nxt = 1'h0;
      if (cfgDone_r && dmRxValid && mode_r != MODE_DUAL) begin
         // Also done in minimum loopback; the line side then drops it
         dlBit_nxt = dmRxBit; // RL7
         dlTog_nxt = ~dlTog_r;
      end
      if (cfgDone_r && mode_r == MODE_DUAL) begin
         dmTxValid_nxt = dmRxValid; // RL10
         dmTxBit_nxt = dmRxValid ? dmRxBit : dmTxBit_r;
      end else if (cfgDone_r && ldPulse) begin
         dmTxValid_nxt = 1'h1; // RL8
         dmTxBit_nxt = ldBit;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dlBit_r <= 1'h0;
         dlTog_r <= 1'h0;
         dmTxBit_r <= 1'h0;
         dmTxValid_r <= 1'h0;
      end else if (ce) begin
         dlBit_r <= dlBit_nxt;
         dlTog_r <= dlTog_nxt;
         dmTxBit_r <= dmTxBit_nxt;
         dmTxValid_r <= dmTxValid_nxt;
      end
   end

   assign dmTxBit = dmTxBit_r;
   assign dmTxValid = dmTxValid_r;
   assign activeMode = mode_r;
   assign octetActive = octetEn_r;
   assign cfgReady = cfgDone_r;

   a_cfg_decode: assert property (@(posedge mclk) disable iff (!nrst) // RL2
      (ce && cfgCnt_r == CFG_LOAD_CNT)
      |=> (mode_r == cdtl_mode_t'({$past(swSync_r[SW_MODE_B]), $past(swSync_r[SW_MODE_A])})))
      else $error("mode not decoded from switches");

   a_cfg_frozen: assert property (@(posedge mclk) disable iff (!nrst) // RL16
      cfgDone_r |=> ($stable(mode_r) && $stable(octetEn_r) && cfgDone_r))
      else $error("configuration changed after load");

   a_dual_echo: assert property (@(posedge mclk) disable iff (!nrst) // RL10
      (ce && cfgDone_r && mode_r == MODE_DUAL && dmRxValid)
      |=> (dmTxValid_r && dmTxBit_r == $past(dmRxBit)))
      else $error("dual loopback echo missing");

   a_line_fwd: assert property (@(posedge mclk) disable iff (!nrst) // RL8
      (ce && cfgDone_r && mode_r != MODE_DUAL && ldPulse)
      |=> (dmTxValid_r && dmTxBit_r == $past(ldBit)))
      else $error("line data not forwarded inward");

   a_int_only: assert property (@(posedge mclk) disable iff (!nrst) // RL4
      (tickTog != $past(tickTog)) |-> ($past(mode_r) == MODE_INTERNAL))
      else $error("bit clock ran outside internal timing");

   // ------------------------------------------------------------
   // Line clock domain
   // ------------------------------------------------------------
   logic lrstMeta_r;
   logic lineRstN;
   logic [3:0] cfgMetaL_r;
   logic [3:0] cfgL_r;
   cdtl_mode_t modeL;
   logic octetEnL;
   logic cfgDoneL;
   logic rxMeta_r;
   logic rxSync_r;
   logic rxLatch_r;
   logic rxLatch_nxt;
   logic tickPulse;
   logic dlPulse;
   logic dlBitL;
   logic txHold_r;
   logic txHold_nxt;
   logic ldBitL_nxt;
   logic ldTogL_nxt;
   logic [2:0] bitIdx_r;
   logic [2:0] bitIdx_nxt;
   logic slot;
   logic lineTxBit_r;
   logic lineTxBit_nxt;
   logic lineTxValid_r;
   logic lineTxValid_nxt;
   logic lineTxOctet_r;
   logic lineTxOctet_nxt;

   // Reset enters at once and leaves in step with the line clock
   always_ff @(posedge lineClk or negedge nrst) begin
      if (!nrst) begin
         lrstMeta_r <= 1'h0;
         lineRstN <= 1'h0;
      end else begin
         lrstMeta_r <= 1'h1;
         lineRstN <= lrstMeta_r;
      end
   end

   cdtl_evt_sync #(.W(1)) u_tickToLine (
      .clk(lineClk),
      .rstN(lineRstN),
      .ce(1'h1),
      .srcTog(tickTog),
      .srcData(1'h0),
      .evtPulse(tickPulse),
      .evtData()
   );

   cdtl_evt_sync #(.W(1)) u_dmToLine (
      .clk(lineClk),
      .rstN(lineRstN),
      .ce(1'h1),
      .srcTog(dlTog_r),
      .srcData(dlBit_r),
      .evtPulse(dlPulse),
      .evtData(dlBitL)
   );

   assign modeL = cdtl_mode_t'(cfgL_r[1:0]);
   assign octetEnL = cfgL_r[2];
   assign cfgDoneL = cfgL_r[3];

   always_comb begin
      rxLatch_nxt = rxSync_r ^ RX_INVERT; // RL6
      txHold_nxt = dlPulse ? dlBitL : txHold_r;
      ldBitL_nxt = ldBitL_r;
      ldTogL_nxt = ldTogL_r;
      if (cfgDoneL && modeL != MODE_DUAL) begin
         // One line bit per edge; mclk must exceed three times the bit rate
         ldBitL_nxt = rxLatch_r; // RL8
         ldTogL_nxt = ~ldTogL_r;
      end
      // Only internal timing waits for the local clock; all else is line timed
      slot = cfgDoneL && ((modeL == MODE_INTERNAL) ? tickPulse : 1'h1); // RL4 RL5 RL9
      unique case (modeL)
         MODE_MINLOOP: lineTxBit_nxt = rxLatch_r; // RL6 RL7
         MODE_DUAL: lineTxBit_nxt = rxLatch_r; // RL11
         MODE_LOOP, MODE_INTERNAL: lineTxBit_nxt = txHold_r;
      endcase
      if (!slot) begin
         lineTxBit_nxt = lineTxBit_r;
      end
      lineTxValid_nxt = slot;
      bitIdx_nxt = slot ? bitIdx_r + 3'h1 : bitIdx_r;
      lineTxOctet_nxt = slot && octetEnL && modeL != MODE_MINLOOP
         && bitIdx_r == OCTET_MARK_IDX; // RL1 RL3
   end

   always_ff @(posedge lineClk or negedge lineRstN) begin
      if (!lineRstN) begin
         cfgMetaL_r <= '0;
         cfgL_r <= '0;
         rxMeta_r <= 1'h0;
         rxSync_r <= 1'h0;
         rxLatch_r <= 1'h0;
         txHold_r <= 1'h0;
         ldBitL_r <= 1'h0;
         ldTogL_r <= 1'h0;
         bitIdx_r <= OCTET_IDX_RESET;
         lineTxBit_r <= 1'h0;
         lineTxValid_r <= 1'h0;
         lineTxOctet_r <= 1'h0;
      end else begin
         cfgMetaL_r <= {cfgDone_r, octetEn_r, mode_r};
         cfgL_r <= cfgMetaL_r;
         rxMeta_r <= lineRxBit;
         rxSync_r <= rxMeta_r;
         rxLatch_r <= rxLatch_nxt;
         txHold_r <= txHold_nxt;
         ldBitL_r <= ldBitL_nxt;
         ldTogL_r <= ldTogL_nxt;
         bitIdx_r <= bitIdx_nxt;
         lineTxBit_r <= lineTxBit_nxt;
         lineTxValid_r <= lineTxValid_nxt;
         lineTxOctet_r <= lineTxOctet_nxt;
      end
   end

   assign lineTxBit = lineTxBit_r;
   assign lineTxValid = lineTxValid_r;
   assign lineTxOctet = lineTxOctet_r;

   a_octet_off: assert property (@(posedge lineClk) disable iff (!lineRstN) // RL1
      (!octetEnL && $stable(octetEnL)) |=> !lineTxOctet_r)
      else $error("octet marker while disabled");

   a_octet_bit8: assert property (@(posedge lineClk) disable iff (!lineRstN) // RL3
      lineTxOctet_r |-> ($past(bitIdx_r) == OCTET_MARK_IDX && lineTxValid_r))
      else $error("octet marker off bit 8");

   a_loop_timed: assert property (@(posedge lineClk) disable iff (!lineRstN) // RL5
      (cfgDoneL && modeL == MODE_LOOP) [*2] |=> lineTxValid_r)
      else $error("loop timing missed a line slot");

   a_min_return: assert property (@(posedge lineClk) disable iff (!lineRstN) // RL6
      (cfgDoneL && modeL == MODE_MINLOOP)
      |=> (lineTxValid_r && lineTxBit_r == $past(rxLatch_r)))
      else $error("minimum loopback did not return line data");

   a_dual_line: assert property (@(posedge lineClk) disable iff (!lineRstN) // RL11
      (cfgDoneL && modeL == MODE_DUAL) |-> ##2 (lineTxBit_r == ($past(rxSync_r, 2) ^ RX_INVERT)))
      else $error("dual loopback line path broken");

endmodule

// [verification/cdtl_line_partner.sv]
module cdtl_line_partner (
   output logic lineClk,
   output logic lineRxBit,
   output logic [3:0] runLen
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // Line timing source
   // ------------------------------------------------------------
   // A recovered line clock runs continuously, so it is never stopped here
   initial begin
      lineClk = 1'b0;
      #7.3;
      forever #24 lineClk = ~lineClk;
   end

   // ------------------------------------------------------------
   // Line data
   // ------------------------------------------------------------
   // Runs of 12 bits let the bench tell which bit must come back despite pipeline depth
   // One process owns the data pin and its run counter
   initial begin
      lineRxBit = 1'b0;
      runLen = 4'h0;
      forever begin
         @(posedge lineClk);
         if (runLen == 4'hb) begin
            lineRxBit <= 1'($urandom_range(0, 1));
            runLen <= 4'h0;
         end else begin
            runLen <= runLen + 4'h1;
         end
      end
   end
endmodule

// [verification/cdtl_line_timing_tb.sv]
module cdtl_line_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cdtl_pkg::*;

   logic mclk = 1'b0;
   logic nrst, ce, lineClk, octSw, swA, swB, dmRxBit, dmRxValid, lineRxBit;
   logic dmTxBit, dmTxValid, lineTxBit, lineTxValid, lineTxOctet, octetActive, cfgReady;
   logic [3:0] runLen;
   cdtl_mode_t activeMode, expMode;
   int num_errors, checked, cyc, lastRise, sinceMark, markCnt, fwdCnt;
   logic mon, seenMark, prevLtv, takenQ, takenBit, lastDm, expOct;
   realtime lastDmT;

   cdtl_line_timing dut_u (.mclk(mclk), .nrst(nrst), .ce(ce), .lineClk(lineClk),
      .octetTimingSwitch(octSw), .timingModeSwitchA(swA), .timingModeSwitchB(swB),
      .dmRxBit(dmRxBit), .dmRxValid(dmRxValid), .lineRxBit(lineRxBit),
      .dmTxBit(dmTxBit), .dmTxValid(dmTxValid), .lineTxBit(lineTxBit),
      .lineTxValid(lineTxValid), .lineTxOctet(lineTxOctet), .activeMode(activeMode),
      .octetActive(octetActive), .cfgReady(cfgReady));

   cdtl_line_partner partner_u (.lineClk(lineClk), .lineRxBit(lineRxBit), .runLen(runLen));

   always #2 mclk = ~mclk;

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   // Decoded from the switch table itself, not from the enum's encoding
   function automatic cdtl_mode_t exp_mode(input logic a, input logic b);
      if (a && b) return MODE_DUAL;
      if (a) return MODE_INTERNAL;
      if (b) return MODE_MINLOOP;
      return MODE_LOOP;
   endfunction

   function automatic int exp_slot();
      return 250_000_000 / 64_000;
   endfunction

   task automatic check(input logic [1:0] got, input logic [1:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Monitors
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      cyc++;
      takenQ <= dmRxValid;
      takenBit <= dmRxBit;
   end

   always @(negedge mclk) begin
      if (mon) begin
         if (expMode == MODE_DUAL) begin
            check(dmTxValid, takenQ);
            if (takenQ) check(dmTxBit, takenBit);
         end else if (dmTxValid === 1'b1) begin
            fwdCnt++;
            if (runLen >= 4'h6) check(dmTxBit, lineRxBit ^ RX_INVERT_DEF);
         end
         if (expMode == MODE_INTERNAL && lineTxValid === 1'b1 && !prevLtv) begin
            if (lastRise > 0) begin
               check((cyc - lastRise - exp_slot()) inside {[-30:30]}, 1'b1);
            end
            lastRise = cyc;
         end
      end
      prevLtv = lineTxValid;
   end

   always @(negedge lineClk) begin
      if (mon) begin
         if (expMode != MODE_INTERNAL) check(lineTxValid, 1'b1);
         if (lineTxValid === 1'b1) begin
            sinceMark++;
            if (expMode == MODE_MINLOOP || expMode == MODE_DUAL) begin
               if (runLen >= 4'h6) check(lineTxBit, lineRxBit ^ RX_INVERT_DEF);
            end else if ($realtime - lastDmT > 300.0) begin
               check(lineTxBit, lastDm);
            end
            if (lineTxOctet === 1'b1) begin
               check(expOct, 1'b1);
               if (seenMark) check(sinceMark == 8, 1'b1);
               seenMark = 1'b1;
               sinceMark = 0;
               markCnt++;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic run_combo(input int i);
      int n;
      int gap;
      logic b;
      mon = 1'b0;
      @(posedge mclk);
      nrst <= 1'b0;
      octSw <= i[0];
      swA <= i[1];
      swB <= i[2];
      expMode = exp_mode(i[1], i[2]);
      expOct = i[0] && expMode != MODE_MINLOOP;
      // Long enough for three line clock edges as well
      repeat (40) @(posedge mclk);
      nrst <= 1'b1;
      n = 0;
      while (cfgReady !== 1'b1 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      check(cfgReady, 1'b1);
      check(activeMode, expMode);
      check(octetActive, i[0]);
      // Switches moved after loading must change nothing
      @(posedge mclk);
      octSw <= ~i[0];
      swA <= ~i[1];
      swB <= ~i[2];
      // Random enable gaps: frozen or running, the loaded setting must hold
      repeat (400) begin
         @(posedge mclk);
         ce <= 1'($urandom_range(0, 1));
      end
      @(posedge mclk);
      ce <= 1'b1;
      check(activeMode, expMode);
      check(octetActive, i[0]);
      lastRise = 0;
      seenMark = 1'b0;
      sinceMark = 0;
      markCnt = 0;
      lastDm = 1'b0;
      lastDmT = 0.0;
      fwdCnt = 0;
      mon = 1'b1;
      n = 0;
      while (n < ((expMode == MODE_INTERNAL) ? 16000 : 3000)) begin
         // Dual loopback takes internal bits back to back
         // Other modes hold each bit long enough to be seen settled on the line
         if (expMode == MODE_DUAL) gap = $urandom_range(0, 2);
         else if (expMode == MODE_INTERNAL) gap = $urandom_range(100, 900);
         else gap = $urandom_range(100, 160);
         b = 1'($urandom_range(0, 1));
         @(posedge mclk);
         dmRxValid <= 1'b1;
         dmRxBit <= b;
         lastDm = b;
         lastDmT = $realtime;
         if (gap > 0) begin
            @(posedge mclk);
            dmRxValid <= 1'b0;
            repeat (gap - 1) @(posedge mclk);
         end
         n += gap + 1;
      end
      @(posedge mclk);
      dmRxValid <= 1'b0;
      @(posedge mclk);
      mon = 1'b0;
      if (expMode != MODE_INTERNAL) check(markCnt > 0, expOct);
      if (expMode == MODE_INTERNAL) check(lastRise > 0, 1'b1);
      if (expMode != MODE_DUAL) check(fwdCnt > 0, 1'b1);
   endtask

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      octSw = 1'b0;
      swA = 1'b0;
      swB = 1'b0;
      dmRxBit = 1'b0;
      dmRxValid = 1'b0;
      mon = 1'b0;
      prevLtv = 1'b0;
      num_errors = 0;
      checked = 0;
      cyc = 0;
      expMode = MODE_LOOP;
      expOct = 1'b0;
      void'($urandom(87121));
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      // Every switch setting, relay and multiplexer recommendations among them
      for (int i = 0; i < 8; i++) run_combo(i);
      conclude();
   end

   initial begin
      #400_000;
      num_errors++;
      $display("unexpected at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
